// *** include/scr_params.svh ***
// Register selects, control field positions and reset values for the system control bank
`ifndef SCR_PARAMS_SVH
`define SCR_PARAMS_SVH
`define SCR_CRN_CTRL        4'h1
`define SCR_CRN_CACHE       4'h2
`define SCR_CRN_BUFF        4'h3
`define SCR_CRM_ZERO        4'h0
`define SCR_OP2_DATA        3'h0
`define SCR_OP2_INSTR       3'h1
`define SCR_BIT_IRAM_FILL   19
`define SCR_BIT_IRAM_ON     18
`define SCR_BIT_DRAM_FILL   17
`define SCR_BIT_DRAM_ON     16
`define SCR_BIT_PC_SW_OFF   15
`define SCR_BIT_ROT_REPL    14
`define SCR_BIT_HIVEC       13
`define SCR_BIT_ICACHE      12
`define SCR_BIT_BIG         7
`define SCR_BIT_DCACHE      2
`define SCR_BIT_PROT        0
`define SCR_CTRL_RSV_ONES   32'h0000_0078
`define SCR_REGION_RESET    8'h00
`define SCR_HIVEC_BASE      32'hFFFF_0000
`define SCR_LOVEC_BASE      32'h0000_0000
`define SCR_STRAP_LOAD_EDGES 2'h3
`endif

// *** include/scr_pkg.sv ***
// Types shared by the system control bank modules
package scr_pkg;
   typedef struct packed {
      logic       valid;    // Transfer presented this cycle
      logic       write;    // 1 write transfer, 0 read transfer
      logic [3:0] crn;      // Primary register number
      logic [3:0] crm;      // Secondary register number
      logic [2:0] op2;      // Secondary opcode
      logic [31:0] wdata;   // Write data
   } scr_xfer_s;

   typedef struct packed {
      logic iram_fill_mode;
      logic iram_on;
      logic dram_fill_mode;
      logic dram_on;
      logic pc_load_state_switch_off;
      logic rotating_replacement;
      logic high_vector_select;
      logic icache_on;
      logic byte_order_big;
      logic dcache_on;
      logic protection_on;
   } scr_ctrl_s;

   typedef enum logic [1:0] {
      SCR_SEL_NONE  = 2'b00,
      SCR_SEL_CTRL  = 2'b01,
      SCR_SEL_CACHE = 2'b10,
      SCR_SEL_BUFF  = 2'b11
   } scr_sel_e;
endpackage : scr_pkg

// *** core/scr_decode.sv ***
// Register select decode for coprocessor transfers
`include "scr_params.svh"
module scr_decode
   import scr_pkg::*;
(
   input  wire scr_xfer_s xfer,       // Transfer fields
   output scr_sel_e       sel,        // Which register is addressed
   output logic           instr_side  // Cacheable bank: 1 instruction, 0 data
);
   // Unmatched selectors fall to NONE: reads give zero, writes are dropped
   always_comb begin
      sel        = SCR_SEL_NONE;
      instr_side = 1'b0;
      if (xfer.crm == `SCR_CRM_ZERO) begin
         if (xfer.crn == `SCR_CRN_CTRL && xfer.op2 == `SCR_OP2_DATA) begin // [R3]
            sel = SCR_SEL_CTRL;
         end else if (xfer.crn == `SCR_CRN_CACHE &&
                      (xfer.op2 == `SCR_OP2_DATA || xfer.op2 == `SCR_OP2_INSTR)) begin
            sel        = SCR_SEL_CACHE; // [R17]
            instr_side = (xfer.op2 == `SCR_OP2_INSTR);
         end else if (xfer.crn == `SCR_CRN_BUFF && xfer.op2 == `SCR_OP2_DATA) begin
            sel = SCR_SEL_BUFF; // [R19]
         end
      end
   end
endmodule : scr_decode

// *** core/scr_region_bits.sv ***
// One eight-bit region attribute register with read-as-zero upper bits
`include "scr_params.svh"
module scr_region_bits
   import scr_pkg::*;
(
   input  wire logic        clk_sys,  // System clock
   input  wire logic        nrst,     // Async reset, active low
   input  wire logic        ce,       // Clock enable
   input  wire logic        wr,       // Write strobe
   input  wire logic [31:0] wdata,    // Write data
   output logic      [7:0]  bits_q,   // Stored region bits
   output logic      [31:0] rdata     // Read view, zero-extended
);
   logic [7:0] bits_d;

   // Only bits 7:0 are kept; upper write bits are discarded
   always_comb begin
      bits_d = bits_q;
      if (wr) begin
         bits_d = wdata[7:0]; // [R18] [R20] [R22]
      end
   end

   // Region settings reset to zero to keep a defined value
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         bits_q <= `SCR_REGION_RESET;
      end else if (ce) begin
         bits_q <= bits_d;
      end
   end

   assign rdata = {24'h00_0000, bits_q}; // [R22]
endmodule : scr_region_bits

// *** core/scr_bank.sv ***
// System control coprocessor register bank: control, cacheable and bufferable registers
// How it works
// [R1] Software writes zero and one into reserved control bits, or read-modify-writes.
// [R2] Reserved control bit reads are unpredictable; here they return the one/zero pattern.
// [R3] Control register sits at c1, c0, secondary opcode 0.
// [R4] Bit 19 steers stores in instruction RAM range into instruction RAM.
// [R5] Bit 18 sends all accesses in instruction RAM range to instruction RAM.
// [R6] Bit 17 writes reloaded data stores into data RAM.
// [R7] Bit 16 enables data RAM with priority over cache and bus.
// [R8] Bit 15 clear lets loaded bit 0 choose compressed state on PC load.
// [R9] Bit 14 picks round-robin replacement, else pseudo-random.
// [R10] Bit 13 picks vector base 0xFFFF0000, else zero.
// [R11] Vector select bit loads from the strap during reset; here it copies the strap for the first three enabled edges after reset.
// [R12] Instruction cache runs only with bit 12 and protection on.
// [R13] Bit 7 picks big-endian, else little-endian.
// [R14] Data cache runs only with bit 2 and protection on.
// [R15] Bit 0 enables protection; reset keeps caches and write buffer off.
// [R16] Software programs a region before enabling protection.
// [R17] c2 opcode 0 is data cacheable bits, opcode 1 instruction.
// [R18] Cacheable bit n marks region n cacheable, per side.
// [R19] Bufferable bits at c3 apply to data accesses only.
// [R20] Bufferable bit n makes data region n write-buffered.
// [R21] Region enables reset to zero; settings ignored while protection off.
// [R22] Region registers read zero above bit 7 and ignore such writes.
`include "scr_params.svh"
module scr_bank
   import scr_pkg::*;
(
   input  wire logic        clk_sys,             // System clock, 100 MHz
   input  wire logic        nrst,                // Async reset, active low
   input  wire logic        ce,                  // Clock enable, freezes state when low
   input  wire logic        high_vector_strap,   // Vector strap pin, asynchronous
   input  wire scr_xfer_s   xfer,                // Coprocessor transfer from core
   output logic      [31:0] rdata,               // Read data, registered
   output logic             rvalid,              // Read data valid, one-cycle pulse
   output scr_ctrl_s        ctrl,                // Control fields, registered
   output logic             icache_active,       // Instruction cache may operate
   output logic             dcache_active,       // Data cache may operate
   output logic             wbuf_active,         // Write buffer may operate
   output logic      [31:0] vector_base,         // Exception vector base address
   output logic      [7:0]  data_cacheable,      // Effective data cacheable per region
   output logic      [7:0]  instr_cacheable,     // Effective instruction cacheable per region
   output logic      [7:0]  data_bufferable      // Effective data bufferable per region
);
   scr_sel_e    sel;
   logic        instr_side;
   logic        wr_ctrl;
   logic        wr_dc;
   logic        wr_ic;
   logic        wr_bf;
   logic [7:0]  dc_q;
   logic [7:0]  ic_q;
   logic [7:0]  bf_q;
   logic [31:0] dc_rd;
   logic [31:0] ic_rd;
   logic [31:0] bf_rd;
   logic        strap_s1_q;
   logic        strap_s2_q;
   logic [1:0]  strap_cnt_q;
   logic [1:0]  strap_cnt_d;
   logic        strap_load;
   scr_ctrl_s   ctrl_d;
   logic [31:0] ctrl_word;
   logic [31:0] rdata_d;
   logic        rvalid_d;

   scr_decode u_decode (
      .xfer       (xfer),
      .sel        (sel),
      .instr_side (instr_side)
   );

   // Write strobes per register
   assign wr_ctrl = xfer.valid && xfer.write && (sel == SCR_SEL_CTRL);
   assign wr_dc   = xfer.valid && xfer.write && (sel == SCR_SEL_CACHE) && !instr_side;
   assign wr_ic   = xfer.valid && xfer.write && (sel == SCR_SEL_CACHE) && instr_side;
   assign wr_bf   = xfer.valid && xfer.write && (sel == SCR_SEL_BUFF);

   scr_region_bits u_dcache_bits (
      .clk_sys (clk_sys),
      .nrst    (nrst),
      .ce      (ce),
      .wr      (wr_dc),
      .wdata   (xfer.wdata),
      .bits_q  (dc_q),
      .rdata   (dc_rd)
   );

   scr_region_bits u_icache_bits (
      .clk_sys (clk_sys),
      .nrst    (nrst),
      .ce      (ce),
      .wr      (wr_ic),
      .wdata   (xfer.wdata),
      .bits_q  (ic_q),
      .rdata   (ic_rd)
   );

   scr_region_bits u_buff_bits (
      .clk_sys (clk_sys),
      .nrst    (nrst),
      .ce      (ce),
      .wr      (wr_bf),
      .wdata   (xfer.wdata),
      .bits_q  (bf_q),
      .rdata   (bf_rd)
   );

   // Strap window: vector select copies the synchronised strap for the first enabled
   // edges after reset. The reset branch may only load constants, so the strap shows
   // from the third edge on; a software write closes the window at once
   always_comb begin
      strap_cnt_d = strap_cnt_q;
      if (wr_ctrl) begin
         strap_cnt_d = 2'h0;
      end else if (strap_load) begin
         strap_cnt_d = strap_cnt_q - 2'h1;
      end
   end

   // Strap is a pin, so it is synchronised; the first stage feeds only the second
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         strap_s1_q  <= 1'b0;
         strap_s2_q  <= 1'b0;
         strap_cnt_q <= `SCR_STRAP_LOAD_EDGES;
      end else if (ce) begin
         strap_s1_q  <= high_vector_strap;
         strap_s2_q  <= strap_s1_q;
         strap_cnt_q <= strap_cnt_d;
      end
   end

   assign strap_load = (strap_cnt_q != 2'h0); // [R11]

   // Next control value; software write wins over the strap capture
   always_comb begin
      ctrl_d = ctrl;
      if (strap_load) begin
         ctrl_d.high_vector_select = strap_s2_q; // [R11]
      end
      if (wr_ctrl) begin
         // Reserved positions in the write data are ignored, so R1 slips are harmless
         ctrl_d.iram_fill_mode           = xfer.wdata[`SCR_BIT_IRAM_FILL];
         ctrl_d.iram_on                  = xfer.wdata[`SCR_BIT_IRAM_ON];
         ctrl_d.dram_fill_mode           = xfer.wdata[`SCR_BIT_DRAM_FILL];
         ctrl_d.dram_on                  = xfer.wdata[`SCR_BIT_DRAM_ON];
         ctrl_d.pc_load_state_switch_off = xfer.wdata[`SCR_BIT_PC_SW_OFF];
         ctrl_d.rotating_replacement     = xfer.wdata[`SCR_BIT_ROT_REPL];
         ctrl_d.high_vector_select       = xfer.wdata[`SCR_BIT_HIVEC];
         ctrl_d.icache_on                = xfer.wdata[`SCR_BIT_ICACHE];
         ctrl_d.byte_order_big           = xfer.wdata[`SCR_BIT_BIG];
         ctrl_d.dcache_on                = xfer.wdata[`SCR_BIT_DCACHE];
         ctrl_d.protection_on            = xfer.wdata[`SCR_BIT_PROT];
      end
   end

   // Every control field clears at reset; vector select is then loaded from the strap
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         ctrl <= '0; // [R4] [R5] [R6] [R7] [R8] [R9] [R13] [R15]
      end else if (ce) begin
         ctrl <= ctrl_d;
      end
   end

   // Assemble the readable control word; reserved ones read back as ones
   always_comb begin
      ctrl_word = `SCR_CTRL_RSV_ONES; // [R2]
      ctrl_word[`SCR_BIT_IRAM_FILL] = ctrl.iram_fill_mode;
      ctrl_word[`SCR_BIT_IRAM_ON]   = ctrl.iram_on;
      ctrl_word[`SCR_BIT_DRAM_FILL] = ctrl.dram_fill_mode;
      ctrl_word[`SCR_BIT_DRAM_ON]   = ctrl.dram_on;
      ctrl_word[`SCR_BIT_PC_SW_OFF] = ctrl.pc_load_state_switch_off;
      ctrl_word[`SCR_BIT_ROT_REPL]  = ctrl.rotating_replacement;
      ctrl_word[`SCR_BIT_HIVEC]     = ctrl.high_vector_select;
      ctrl_word[`SCR_BIT_ICACHE]    = ctrl.icache_on;
      ctrl_word[`SCR_BIT_BIG]       = ctrl.byte_order_big;
      ctrl_word[`SCR_BIT_DCACHE]    = ctrl.dcache_on;
      ctrl_word[`SCR_BIT_PROT]      = ctrl.protection_on;
   end

   // Read mux; unmapped selects return zero
   always_comb begin
      rvalid_d = xfer.valid && !xfer.write;
      rdata_d  = rdata;
      if (rvalid_d) begin
         case (sel)
            SCR_SEL_CTRL:  rdata_d = ctrl_word; // [R3]
            SCR_SEL_CACHE: rdata_d = instr_side ? ic_rd : dc_rd; // [R17]
            SCR_SEL_BUFF:  rdata_d = bf_rd;
            SCR_SEL_NONE:  rdata_d = 32'h0000_0000;
            default:       rdata_d = 32'h0000_0000;
         endcase
      end
   end

   // Read data held until the next read; valid pulses one cycle
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         rdata  <= 32'h0000_0000;
         rvalid <= 1'b0;
      end else if (ce) begin
         rdata  <= rdata_d;
         rvalid <= rvalid_d;
      end
   end

   // Effective enables; gating by protection lets one write turn both on together
   assign icache_active = ctrl.icache_on && ctrl.protection_on; // [R12]
   assign dcache_active = ctrl.dcache_on && ctrl.protection_on; // [R14]
   assign wbuf_active   = ctrl.protection_on; // [R15]
   assign vector_base   = ctrl.high_vector_select ? `SCR_HIVEC_BASE : `SCR_LOVEC_BASE; // [R10]

   // Region attributes count only while protection is on; the bufferable set never
   // reaches fetch logic because no instruction-side output carries it
   assign data_cacheable  = ctrl.protection_on ? dc_q : 8'h00; // [R18] [R21]
   assign instr_cacheable = ctrl.protection_on ? ic_q : 8'h00; // [R18] [R21]
   assign data_bufferable = ctrl.protection_on ? bf_q : 8'h00; // [R19] [R20] [R21]

   // Checks: the enables are held against the write data, not the ctrl struct,
   // so a wrong field position on the register path shows up here
   a_icache_gate: assert property (@(posedge clk_sys) disable iff (!nrst) // [R12]
      (ce && wr_ctrl) |=>
      (icache_active == ($past(xfer.wdata[12]) && $past(xfer.wdata[0]))))
      else $error("icache active without both enables");
   a_dcache_gate: assert property (@(posedge clk_sys) disable iff (!nrst) // [R14]
      (ce && wr_ctrl) |=>
      (dcache_active == ($past(xfer.wdata[2]) && $past(xfer.wdata[0]))))
      else $error("dcache active without both enables");
   a_wbuf_off: assert property (@(posedge clk_sys) disable iff (!nrst) // [R15]
      (ce && wr_ctrl) |=>
      (wbuf_active == $past(xfer.wdata[0])))
      else $error("write buffer enable wrong");
   a_vec_base: assert property (@(posedge clk_sys) disable iff (!nrst) // [R10]
      (ce && wr_ctrl) |=>
      (vector_base == ($past(xfer.wdata[13]) ? 32'hFFFF_0000 : 32'h0000_0000)))
      else $error("vector base wrong");
   a_ctrl_write: assert property (@(posedge clk_sys) disable iff (!nrst) // [R3]
      (ce && wr_ctrl) |=>
      (ctrl.icache_on == $past(xfer.wdata[12]) && ctrl.dram_on == $past(xfer.wdata[16]) &&
       ctrl.iram_fill_mode == $past(xfer.wdata[19])))
      else $error("control write not stored");
   a_ctrl_readback: assert property (@(posedge clk_sys) disable iff (!nrst) // [R3]
      (ce && xfer.valid && !xfer.write && sel == SCR_SEL_CTRL) |=>
      (rdata[13] == $past(ctrl.high_vector_select) && rdata[0] == $past(ctrl.protection_on)))
      else $error("control read wrong");

   // Strap capture and its window
   a_strap_load: assert property (@(posedge clk_sys) disable iff (!nrst) // [R11]
      (ce && strap_load && !wr_ctrl) |=>
      (ctrl.high_vector_select == $past(strap_s2_q)))
      else $error("strap not captured");
   a_strap_window: assert property (@(posedge clk_sys) disable iff (!nrst) // [R11]
      (ce && wr_ctrl) |=>
      !strap_load)
      else $error("strap window still open after a write");

   // Region register checks
   a_region_mask: assert property (@(posedge clk_sys) disable iff (!nrst) // [R21]
      !ctrl.protection_on |->
      (data_cacheable == 8'h00 && data_bufferable == 8'h00 && instr_cacheable == 8'h00))
      else $error("region bits leak while protection off");
   a_dcache_write: assert property (@(posedge clk_sys) disable iff (!nrst) // [R18]
      (ce && wr_dc) |=>
      (dc_q == $past(xfer.wdata[7:0]) && ic_q == $past(ic_q)))
      else $error("data cacheable write wrong");
   a_icache_write: assert property (@(posedge clk_sys) disable iff (!nrst) // [R17]
      (ce && wr_ic) |=>
      (ic_q == $past(xfer.wdata[7:0]) && dc_q == $past(dc_q)))
      else $error("instruction cacheable write wrong");
   a_buff_write: assert property (@(posedge clk_sys) disable iff (!nrst) // [R20]
      (ce && wr_bf) |=>
      (bf_q == $past(xfer.wdata[7:0])))
      else $error("bufferable write lost");
   a_unmapped_write: assert property (@(posedge clk_sys) disable iff (!nrst) // [R17]
      (ce && xfer.valid && xfer.write && sel == SCR_SEL_NONE) |=>
      (dc_q == $past(dc_q) && ic_q == $past(ic_q) && bf_q == $past(bf_q)))
      else $error("unmapped write changed a region register");

   // Read path checks
   a_cache_read: assert property (@(posedge clk_sys) disable iff (!nrst) // [R17]
      (ce && xfer.valid && !xfer.write && sel == SCR_SEL_CACHE && instr_side) |=>
      (rvalid && rdata == {24'h00_0000, $past(ic_q)}))
      else $error("instruction cacheable read wrong");
   a_upper_zero: assert property (@(posedge clk_sys) disable iff (!nrst) // [R22]
      (ce && xfer.valid && !xfer.write && sel == SCR_SEL_BUFF) |=>
      (rdata[31:8] == 24'h00_0000))
      else $error("bufferable upper bits not zero");
   a_read_pulse: assert property (@(posedge clk_sys) disable iff (!nrst) // [R3]
      ce |=>
      (rvalid == ($past(xfer.valid) && !$past(xfer.write))))
      else $error("read valid pulse wrong");

   // Scenario covers
   c_ctrl_write: cover property (@(posedge clk_sys) disable iff (!nrst) ce && wr_ctrl);
   c_both_caches: cover property (@(posedge clk_sys) disable iff (!nrst)
      icache_active && dcache_active);
   c_icache_rd: cover property (@(posedge clk_sys) disable iff (!nrst)
      xfer.valid && !xfer.write && sel == SCR_SEL_CACHE && instr_side);
   c_hivec: cover property (@(posedge clk_sys) disable iff (!nrst) ctrl.high_vector_select);
   c_strap_high: cover property (@(posedge clk_sys) disable iff (!nrst)
      strap_load && strap_s2_q);
endmodule : scr_bank

// *** tb/scr_core_model.sv ***
// Behavioural core that issues coprocessor register transfers to the control bank
module scr_core_model
   import scr_pkg::*;
(
   input  wire logic        clk_sys,  // System clock
   output scr_xfer_s        xfer,     // Transfer to the bank
   input  wire logic [31:0] rdata,    // Read data from the bank
   input  wire logic        rvalid    // Read data valid pulse
);
   timeunit 1ns;
   timeprecision 1ps;

   logic region_done = 1'b0;  // Set once any region register was written

   initial xfer = '0;

   // One transfer per edge; the request is left up so writes can run back to back
   task automatic wr(input logic [3:0] crn, input logic [3:0] crm, input logic [2:0] op2,
                     input logic [31:0] d);
      @(posedge clk_sys);
      if (crn != 4'h1) region_done = 1'b1;
      xfer <= {1'b1, 1'b1, crn, crm, op2, d};
   endtask : wr

   // Control writes keep the reserved zero and one fields as the core must
   task automatic wr_ctrl(input logic [31:0] d);
      logic [31:0] w;
      w = (d & 32'h000F_F085) | 32'h0000_0078;
      if (!region_done) w[0] = 1'b0;
      wr(4'h1, 4'h0, 3'h0, w);
   endtask : wr_ctrl

   // Released fields are inverted so a stale value is never mistaken for a live one
   task automatic idle();
      @(posedge clk_sys);
      xfer <= {1'b0, ~xfer[43:0]};
      #1;
   endtask : idle

   // Read: request taken at the next edge, answer sampled just after that same edge
   task automatic rd(input logic [3:0] crn, input logic [3:0] crm, input logic [2:0] op2,
                     output logic [31:0] d, output logic ok);
      @(posedge clk_sys);
      xfer <= {1'b1, 1'b0, crn, crm, op2, ~xfer[31:0]};
      @(posedge clk_sys);
      xfer <= {1'b0, ~xfer[43:0]};
      #1;
      ok = rvalid;
      d  = rdata;
   endtask : rd
endmodule : scr_core_model

// *** tb/tb_top.sv ***
// Self-checking bench for the system control register bank
module tb_top
   import scr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic        clk_sys;
   logic        nrst;
   logic        ce;
   logic        high_vector_strap;
   scr_xfer_s   xfer;
   logic [31:0] rdata;
   logic        rvalid;
   scr_ctrl_s   ctrl;
   logic        icache_active;
   logic        dcache_active;
   logic        wbuf_active;
   logic [31:0] vector_base;
   logic [7:0]  data_cacheable;
   logic [7:0]  instr_cacheable;
   logic [7:0]  data_bufferable;
   int          failures = 0;
   int          check_count = 0;
   int          cycles = 0;
   int          bits[10] = '{19, 18, 17, 16, 15, 14, 13, 12, 7, 2};

   scr_bank scr_bank_inst (
      .clk_sys(clk_sys), .nrst(nrst), .ce(ce), .high_vector_strap(high_vector_strap),
      .xfer(xfer), .rdata(rdata), .rvalid(rvalid), .ctrl(ctrl),
      .icache_active(icache_active), .dcache_active(dcache_active),
      .wbuf_active(wbuf_active), .vector_base(vector_base),
      .data_cacheable(data_cacheable), .instr_cacheable(instr_cacheable),
      .data_bufferable(data_bufferable)
   );

   scr_core_model scr_core_model_inst (
      .clk_sys(clk_sys), .xfer(xfer), .rdata(rdata), .rvalid(rvalid)
   );

   // 100 MHz system clock
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   // Cuts a hang short; the whole run needs under a hundred cycles
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles > 2000) begin
         failures++;
         print_verdict();
      end
   end

   task automatic print_verdict();
      if (failures == 0 && check_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : print_verdict

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
         failures++;
      end
   endtask : chk

   // Control field view expected from a control word
   function automatic logic [10:0] fld(input logic [31:0] w);
      return {w[19:12], w[7], w[2], w[0]};
   endfunction : fld

   // Read one register; reserved positions are masked since their value is not promised
   task automatic rdchk(input logic [3:0] crn, input logic [2:0] op2, input logic [31:0] mask,
                        input logic [31:0] exp);
      logic [31:0] d;
      logic        ok;
      scr_core_model_inst.rd(crn, 4'h0, op2, d, ok);
      chk({31'h0, ok}, 32'h0000_0001);
      chk(d & mask, exp);
   endtask : rdchk

   initial begin
      nrst = 1'b0;
      ce = 1'b1;
      high_vector_strap = 1'b0;
      repeat (3) @(posedge clk_sys);
      nrst <= 1'b1;
      scr_core_model_inst.idle();
      // Reset state with the strap low
      chk({21'h0, ctrl}, 32'h0000_0000);
      chk({29'h0, icache_active, dcache_active, wbuf_active}, 32'h0000_0000);
      chk(vector_base, 32'h0000_0000);
      // Walk every control field alone except protection
      foreach (bits[i]) begin
         scr_core_model_inst.wr_ctrl(32'h0000_0001 << bits[i]);
         scr_core_model_inst.idle();
         chk({21'h0, ctrl}, {21'h0, fld(32'h0000_0001 << bits[i])});
         chk(vector_base, (bits[i] == 13) ? 32'hFFFF_0000 : 32'h0000_0000);
         chk({30'h0, icache_active, dcache_active}, 32'h0000_0000);
         rdchk(4'h1, 3'h0, 32'h000F_F085, 32'h0000_0001 << bits[i]);
      end
      // Region registers back to back, with unmapped selects written after them
      scr_core_model_inst.wr(4'h2, 4'h0, 3'h0, 32'hFFFF_FFA5);
      scr_core_model_inst.wr(4'h2, 4'h0, 3'h1, 32'h1234_563C);
      scr_core_model_inst.wr(4'h3, 4'h0, 3'h0, 32'h0000_0196);
      scr_core_model_inst.wr(4'h2, 4'h0, 3'h2, 32'hFFFF_FFFF);
      scr_core_model_inst.wr(4'h2, 4'h1, 3'h0, 32'hFFFF_FFFF);
      scr_core_model_inst.idle();
      chk({8'h0, data_cacheable, instr_cacheable, data_bufferable}, 32'h0000_0000);
      rdchk(4'h2, 3'h0, 32'hFFFF_FFFF, 32'h0000_00A5);
      rdchk(4'h2, 3'h1, 32'hFFFF_FFFF, 32'h0000_003C);
      rdchk(4'h3, 3'h0, 32'hFFFF_FFFF, 32'h0000_0096);
      rdchk(4'h2, 3'h2, 32'hFFFF_FFFF, 32'h0000_0000);
      // One write turns on both caches and protection
      scr_core_model_inst.wr_ctrl(32'h0000_1005);
      scr_core_model_inst.idle();
      chk({31'h0, icache_active}, 32'h0000_0001);
      chk({31'h0, dcache_active}, 32'h0000_0001);
      chk({31'h0, wbuf_active}, 32'h0000_0001);
      chk({8'h0, data_cacheable, instr_cacheable, data_bufferable}, 32'h00A5_3C96);
      // Bufferable write touches data only
      scr_core_model_inst.wr(4'h3, 4'h0, 3'h0, 32'h0000_0000);
      scr_core_model_inst.idle();
      chk({8'h0, data_cacheable, instr_cacheable, data_bufferable}, 32'h00A5_3C00);
      // Frozen clock enable: the transfer must not be taken
      @(posedge clk_sys);
      ce <= 1'b0;
      scr_core_model_inst.wr_ctrl(32'h0000_0000);
      scr_core_model_inst.idle();
      @(posedge clk_sys);
      ce <= 1'b1;
      #1;
      chk({21'h0, ctrl}, {21'h0, fld(32'h0000_1005)});
      // Second reset with the strap high loads the vector select
      @(posedge clk_sys);
      nrst <= 1'b0;
      high_vector_strap <= 1'b1;
      repeat (3) @(posedge clk_sys);
      nrst <= 1'b1;
      repeat (4) @(posedge clk_sys);
      #1;
      chk({21'h0, ctrl}, {21'h0, fld(32'h0000_2000)});
      chk(vector_base, 32'hFFFF_0000);
      chk({29'h0, icache_active, dcache_active, wbuf_active}, 32'h0000_0000);
      rdchk(4'h1, 3'h0, 32'h000F_F085, 32'h0000_2000);
      // Software may clear it afterwards
      scr_core_model_inst.wr_ctrl(32'h0000_0000);
      scr_core_model_inst.idle();
      chk(vector_base, 32'h0000_0000);
      print_verdict();
   end
endmodule : tb_top
